// ==== hdl/psll_cfg.svh ====
`ifndef PSLL_CFG_SVH
`define PSLL_CFG_SVH

// serial word framing, msb first, select bits last
`define PSLL_WORD_W 24
`define PSLL_PAYLOAD_W 22
`define PSLL_SEL_W 2
`define PSLL_LATCH_N 4
`define PSLL_ALL_WRITTEN 4'hF

// rf divider latch: pump boost flag sits at the top of the payload
`define PSLL_FASTLOCK_BIT 21
// rf reference latch: charge-pump current code field
`define PSLL_PUMP_LSB 17
`define PSLL_PUMP_W 3
`define PSLL_PUMP_MAX 3'h7

// reset values
`define PSLL_WORD_RST 24'h000000
`define PSLL_PAYLOAD_RST 22'h000000
`define PSLL_PUMP_RST 3'h0

`endif

// ==== hdl/psll_latch_bank.sv ====
`timescale 1ns/1ns
`include "psll_cfg.svh"

module psll_latch_bank
    import psll_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // latch access
    psll_latch_if.bank lat
);
    psll_payload_t word_q [`PSLL_LATCH_N];
    psll_payload_t word_d [`PSLL_LATCH_N];

    // only the addressed latch takes the payload; others hold
    always_comb begin
        for (int i = 0; i < `PSLL_LATCH_N; i++) begin
            word_d[i] = word_q[i];
        end
        if (lat.wr_en) begin
            word_d[lat.wr_sel] = lat.wr_data;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        for (int i = 0; i < `PSLL_LATCH_N; i++) begin
            word_q[i] <= reset_n_i ? word_d[i] : `PSLL_PAYLOAD_RST;
        end
    end

    assign lat.word = word_q;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    property p_decode_if_ref;
        lat.wr_en && lat.wr_sel == PSLL_IF_REF
            |=> word_q[0] == $past(lat.wr_data) && $stable(word_q[3]);
    endproperty
    a_decode_if_ref: assert property (p_decode_if_ref)
        else $error("if reference latch not loaded alone");

    property p_decode_rf_div;
        lat.wr_en && lat.wr_sel == PSLL_RF_DIV
            |=> word_q[3] == $past(lat.wr_data) && $stable(word_q[0]) && $stable(word_q[2]);
    endproperty
    a_decode_rf_div: assert property (p_decode_rf_div)
        else $error("rf divider latch not loaded alone");

    property p_hold_idle;
        !lat.wr_en |=> $stable(word_q[1]) && $stable(word_q[2]);
    endproperty
    a_hold_idle: assert property (p_hold_idle)
        else $error("latch changed without a transfer");
endmodule : psll_latch_bank

// ==== hdl/psll_latch_if.sv ====
`timescale 1ns/1ns
`include "psll_cfg.svh"

interface psll_latch_if;
    import psll_pkg::*;
    logic wr_en;
    psll_latch_t wr_sel;
    psll_payload_t wr_data;
    psll_payload_t word [`PSLL_LATCH_N];

    modport loader (output wr_en, output wr_sel, output wr_data, input word);
    modport bank (input wr_en, input wr_sel, input wr_data, output word);
endinterface : psll_latch_if

// ==== hdl/psll_loader.sv ====
`timescale 1ns/1ns
`include "psll_cfg.svh"

module psll_loader
    import psll_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // three-wire serial port
    input wire logic shift_clk_i,
    input wire logic serial_input_bit_i,
    input wire logic transfer_strobe_i,
    // latch contents
    output logic [`PSLL_PAYLOAD_W-1:0] if_ref_word_o,
    output logic [`PSLL_PAYLOAD_W-1:0] if_div_word_o,
    output logic [`PSLL_PAYLOAD_W-1:0] rf_ref_word_o,
    output logic [`PSLL_PAYLOAD_W-1:0] rf_div_word_o,
    // fast-lock and loop controls
    output logic [`PSLL_PUMP_W-1:0] rf_pump_current_o,
    output logic fastlock_switch_pin_o,
    output logic fastlock_switch_pin_oe_o,
    output logic output_active_o
);
    psll_latch_if lat ();

    psll_latch_bank u_bank (
        .ref_clk_i (ref_clk_i),
        .reset_n_i (reset_n_i),
        .lat (lat)
    );

    // payload is everything above the select bits
    function automatic psll_payload_t payload_of(input psll_word_t w);
        return w[`PSLL_WORD_W-1:`PSLL_SEL_W];
    endfunction : payload_of

    function automatic psll_latch_t select_of(input psll_word_t w);
        return psll_latch_t'(w[`PSLL_SEL_W-1:0]);
    endfunction : select_of

    // serial front end state
    psll_word_t shift_q, shift_d;
    logic sck_prev_q, sck_prev_d;
    logic strobe_prev_q, strobe_prev_d;
    logic sck_rise, strobe_rise;
    logic [`PSLL_LATCH_N-1:0] written_q, written_d;

    // edges found by comparing against last sample; pins are synchronous
    assign sck_rise = shift_clk_i && !sck_prev_q;
    assign strobe_rise = transfer_strobe_i && !strobe_prev_q;

    // no power-down gating here, so loading works in every power state
    always_comb begin
        sck_prev_d = shift_clk_i;
        strobe_prev_d = transfer_strobe_i;
        shift_d = shift_q;
        written_d = written_q;
        if (sck_rise) begin
            shift_d = {shift_q[`PSLL_WORD_W-2:0], serial_input_bit_i};
        end
        if (strobe_rise) begin
            written_d[select_of(shift_q)] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            sck_prev_q <= 1'b0;
            strobe_prev_q <= 1'b0;
            shift_q <= `PSLL_WORD_RST;
            written_q <= '0;
        end else begin
            sck_prev_q <= sck_prev_d;
            strobe_prev_q <= strobe_prev_d;
            shift_q <= shift_d;
            written_q <= written_d;
        end
    end

    // strobe edge uses the word as it stood before this cycle's shift
    assign lat.wr_en = strobe_rise;
    assign lat.wr_sel = select_of(shift_q);
    assign lat.wr_data = payload_of(shift_q);

    // output stage: every top output except the constant-low switch pin is registered here
    logic fastlock;
    logic [`PSLL_PUMP_W-1:0] pump_d, pump_q;
    logic pin_oe_d, pin_oe_q;
    logic active_d, active_q;
    psll_payload_t words_q [`PSLL_LATCH_N];

    // flag lives in the divider latch, so one write both retunes and boosts
    assign fastlock = lat.word[PSLL_RF_DIV][`PSLL_FASTLOCK_BIT];

    always_comb begin
        pump_d = lat.word[PSLL_RF_REF][`PSLL_PUMP_LSB +: `PSLL_PUMP_W];
        if (fastlock) begin
            pump_d = `PSLL_PUMP_MAX;
        end
        pin_oe_d = fastlock;
        active_d = (written_q == `PSLL_ALL_WRITTEN);
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            pump_q <= `PSLL_PUMP_RST;
            pin_oe_q <= 1'b0;
            active_q <= 1'b0;
            for (int i = 0; i < `PSLL_LATCH_N; i++) begin
                words_q[i] <= `PSLL_PAYLOAD_RST;
            end
        end else begin
            pump_q <= pump_d;
            pin_oe_q <= pin_oe_d;
            active_q <= active_d;
            for (int i = 0; i < `PSLL_LATCH_N; i++) begin
                words_q[i] <= lat.word[i];
            end
        end
    end

    assign if_ref_word_o = words_q[PSLL_IF_REF];
    assign if_div_word_o = words_q[PSLL_IF_DIV];
    assign rf_ref_word_o = words_q[PSLL_RF_REF];
    assign rf_div_word_o = words_q[PSLL_RF_DIV];
    assign rf_pump_current_o = pump_q;
    assign fastlock_switch_pin_o = 1'b0; // open drain: only ever pulls low
    assign fastlock_switch_pin_oe_o = pin_oe_q;
    assign output_active_o = active_q;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_rf_div_write(bit flag);
        strobe_rise && select_of(shift_q) == PSLL_RF_DIV
            && shift_q[`PSLL_FASTLOCK_BIT + `PSLL_SEL_W] == flag;
    endsequence

    property p_shift_in;
        sck_rise |=> shift_q == {$past(shift_q[`PSLL_WORD_W-2:0]), $past(serial_input_bit_i)};
    endproperty
    a_shift_in: assert property (p_shift_in)
        else $error("serial bit not shifted in on shift clock edge");

    property p_no_shift_idle;
        !sck_rise |=> $stable(shift_q);
    endproperty
    a_no_shift_idle: assert property (p_no_shift_idle)
        else $error("shift register moved without a shift edge");

    property p_one_write_starts;
        s_rf_div_write(1'b1) |-> ##2 fastlock_switch_pin_oe_o
            && rf_pump_current_o == `PSLL_PUMP_MAX
            && rf_div_word_o == $past(payload_of(shift_q), 2);
    endproperty
    a_one_write_starts: assert property (p_one_write_starts)
        else $error("single divider write did not load and start fast-lock");

    property p_exit_fastlock;
        s_rf_div_write(1'b0) |-> ##2 !fastlock_switch_pin_oe_o;
    endproperty
    a_exit_fastlock: assert property (p_exit_fastlock)
        else $error("fast-lock still on after flag cleared");

    property p_pump_forced;
        fastlock |=> rf_pump_current_o == `PSLL_PUMP_MAX;
    endproperty
    a_pump_forced: assert property (p_pump_forced)
        else $error("pump current not at maximum during fast-lock");

    property p_pin_follows;
        fastlock_switch_pin_oe_o == $past(fastlock) && !fastlock_switch_pin_o;
    endproperty
    a_pin_follows: assert property (p_pin_follows)
        else $error("switch pin does not follow fast-lock");

    property p_active_gate;
        output_active_o |-> $past(written_q) == `PSLL_ALL_WRITTEN;
    endproperty
    a_active_gate: assert property (p_active_gate)
        else $error("output active before four latch writes");

    property p_active_sticky;
        output_active_o |=> output_active_o;
    endproperty
    a_active_sticky: assert property (p_active_sticky)
        else $error("output went inactive without reset");

    property p_strobe_loads;
        strobe_rise |-> ##2 words_q[$past(select_of(shift_q), 2)] == $past(payload_of(shift_q), 2);
    endproperty
    a_strobe_loads: assert property (p_strobe_loads)
        else $error("strobe did not load the selected latch");

    property p_strobe_marks;
        strobe_rise |=> written_q[$past(select_of(shift_q))];
    endproperty
    a_strobe_marks: assert property (p_strobe_marks)
        else $error("strobe did not mark its latch as written");

    // a mask that moved on its own would open the output early
    property p_written_hold;
        !strobe_rise |=> $stable(written_q);
    endproperty
    a_written_hold: assert property (p_written_hold)
        else $error("write mask changed without a strobe");

    // outside fast-lock the programmed current code goes straight through
    property p_pump_code;
        !fastlock |=> rf_pump_current_o
            == $past(lat.word[PSLL_RF_REF][`PSLL_PUMP_LSB +: `PSLL_PUMP_W]);
    endproperty
    a_pump_code: assert property (p_pump_code)
        else $error("pump current differs from programmed code outside fast-lock");
endmodule : psll_loader

// ==== hdl/psll_pkg.sv ====
`include "psll_cfg.svh"

package psll_pkg;
    // latch chosen by the two select bits, in select-code order
    typedef enum logic [`PSLL_SEL_W-1:0] {
        PSLL_IF_REF,
        PSLL_IF_DIV,
        PSLL_RF_REF,
        PSLL_RF_DIV
    } psll_latch_t;

    typedef logic [`PSLL_PAYLOAD_W-1:0] psll_payload_t;
    typedef logic [`PSLL_WORD_W-1:0] psll_word_t;
endpackage : psll_pkg

// ==== verif/psll_host_model.sv ====
`timescale 1ns/1ns

module psll_host_model (
    // system clock
    input wire logic ref_clk_i,
    // serial port drive
    output logic shift_clk_o,
    output logic serial_input_bit_o,
    output logic transfer_strobe_o
);
    // shift clock parked low outside frames
    initial begin
        shift_clk_o = 1'b0;
        serial_input_bit_o = 1'b0;
        transfer_strobe_o = 1'b0;
    end

    // two system cycles per level keeps the bit rate at 12.5 MHz
    task automatic hold2();
        repeat (2) @(posedge ref_clk_i);
        #2;
    endtask : hold2

    // one whole word, msb first, strobe raised only after the last bit
    task automatic send_word(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            serial_input_bit_o = w[i];
            shift_clk_o = 1'b0;
            hold2();
            shift_clk_o = 1'b1;
            hold2();
        end
        shift_clk_o = 1'b0;
        serial_input_bit_o = ~w[0]; // released line shows no stale bit
        hold2();
        transfer_strobe_o = 1'b1;
        hold2();
        transfer_strobe_o = 1'b0;
    endtask : send_word
endmodule : psll_host_model

// ==== verif/tb_pll_serial_latch_loader.sv ====
`timescale 1ns/1ns

module tb_pll_serial_latch_loader;
    import psll_pkg::*;
    typedef struct packed {
        logic [21:0] pay;
        logic [1:0] sel;
        logic [2:0] pump;
        logic oe;
        logic act;
    } psll_row_t;

    logic ref_clk_i;
    logic reset_n_i;
    logic shift_clk;
    logic sdi;
    logic strobe;
    logic [21:0] if_ref_w, if_div_w, rf_ref_w, rf_div_w;
    logic [2:0] pump;
    logic pin, pin_oe, active;
    int err_total = 0;
    int samples_checked = 0;
    int cyc = 0;
    psll_row_t rows [6];
    psll_payload_t exp_w [4];

    psll_loader dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .shift_clk_i(shift_clk),
        .serial_input_bit_i(sdi), .transfer_strobe_i(strobe), .if_ref_word_o(if_ref_w),
        .if_div_word_o(if_div_w), .rf_ref_word_o(rf_ref_w), .rf_div_word_o(rf_div_w),
        .rf_pump_current_o(pump), .fastlock_switch_pin_o(pin),
        .fastlock_switch_pin_oe_o(pin_oe), .output_active_o(active));
    psll_host_model host (.ref_clk_i(ref_clk_i), .shift_clk_o(shift_clk),
        .serial_input_bit_o(sdi), .transfer_strobe_o(strobe));

    // free-running system clock
    initial begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end

    task automatic chk(input string what, input logic [21:0] exp, input logic [21:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test

    // a hang is cut well past the ~1140 cycles the run needs
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_total++;
            $display("timeout");
            finish_test();
        end
    end

    task automatic settle();
        repeat (3) @(posedge ref_clk_i);
        #2;
    endtask : settle

    initial begin
        reset_n_i = 1'b0;
        // pump code 5 sits in rf ref bits 19..17
        rows = '{'{22'h2AAAAA, 2'h0, 3'h0, 1'b0, 1'b0},
                 '{22'h155555, 2'h1, 3'h0, 1'b0, 1'b0},
                 '{22'h0A0001, 2'h2, 3'h5, 1'b0, 1'b0},
                 '{22'h0ABCDE, 2'h3, 3'h5, 1'b0, 1'b1},
                 '{22'h3ABCDE, 2'h3, 3'h7, 1'b1, 1'b1},
                 '{22'h0BCDEF, 2'h3, 3'h5, 1'b0, 1'b1}};
        foreach (exp_w[k])
            exp_w[k] = 22'h000000;
        repeat (2) @(posedge ref_clk_i);
        #2;
        reset_n_i = 1'b1;
        chk("active", 22'h0, 22'(active));
        for (int i = 0; i < 6; i++) begin
            host.send_word({rows[i].pay, rows[i].sel});
            exp_w[rows[i].sel] = rows[i].pay;
            settle();
            chk("if_ref", exp_w[0], if_ref_w);
            chk("if_div", exp_w[1], if_div_w);
            chk("rf_ref", exp_w[2], rf_ref_w);
            chk("rf_div", exp_w[3], rf_div_w);
            chk("pump", 22'(rows[i].pump), 22'(pump));
            chk("pin_oe", 22'(rows[i].oe), 22'(pin_oe));
            chk("pin", 22'h0, 22'(pin));
            chk("active", 22'(rows[i].act), 22'(active));
            $display("row %0d done", i);
        end
        // reset in mid-run while fast-lock is on
        host.send_word({22'h200001, 2'h3});
        settle();
        chk("pin_oe", 22'h1, 22'(pin_oe));
        reset_n_i = 1'b0;
        settle();
        reset_n_i = 1'b1;
        chk("pin_oe", 22'h0, 22'(pin_oe));
        chk("rf_div", 22'h0, rf_div_w);
        chk("pump", 22'h0, 22'(pump));
        chk("active", 22'h0, 22'(active));
        $display("reset test done");
        // one write after reset: fast-lock on, output still inactive
        host.send_word({22'h200003, 2'h3});
        settle();
        chk("rf_div", 22'h200003, rf_div_w);
        chk("pump", 22'h7, 22'(pump));
        chk("pin_oe", 22'h1, 22'(pin_oe));
        chk("active", 22'h0, 22'(active));
        $display("single write test done");
        // rewrites of one latch leave fast-lock, and three of them keep the output off
        for (int n = 0; n < 3; n++) begin
            host.send_word({22'h000005, 2'h3});
            settle();
            chk("pin_oe", 22'h0, 22'(pin_oe));
            chk("pump", 22'h0, 22'(pump));
            chk("active", 22'h0, 22'(active));
        end
        $display("repeat write test done");
        finish_test();
    end
endmodule : tb_pll_serial_latch_loader
